// ==== src/oac_pkg.sv ====
package oac_pkg;
   // register map
   localparam logic [15:0] OAC_SCAN_ADDR  = 16'h843e;
   localparam logic [15:0] OAC_SRT_ADDR   = 16'h843f;
   localparam logic [15:0] OAC_ATT2_BASE  = 16'h8440;
   localparam logic [15:0] OAC_ATT4_BASE  = 16'h8500;
   localparam int          OAC_ATT2_BYTES = 64;
   localparam int          OAC_ATT4_BYTES = 128;
   // field positions
   localparam int OAC_SCAN_RNG_LSB = 0;
   localparam int OAC_VBLANK_BIT   = 2;
   localparam int OAC_OVR_BIT      = 3;
   localparam int OAC_CLAMP_BIT    = 5;
   localparam int OAC_SWRST_BIT    = 0;
   localparam int OAC_AID_BIT      = 6;
   localparam int OAC_C1_LSB       = 0;
   localparam int OAC_C2_LSB       = 9;
   localparam int OAC_FX_LSB       = 18;
   localparam int OAC_C3_LSB       = 32;
   localparam int OAC_C4_LSB       = 41;
   // reset values and writable-bit masks
   localparam logic [7:0]  OAC_SCAN_RESET = 8'h00;
   localparam logic [7:0]  OAC_SRT_RESET  = 8'h00;
   localparam logic [7:0]  OAC_ATT_RESET  = 8'h00;
   localparam logic [7:0]  OAC_SCAN_MASK  = 8'h2f;
   localparam logic [31:0] OAC_ATT2_MASK  = 32'h003f_ffff;
   localparam logic [63:0] OAC_ATT4_MASK  = 64'h0003_ffff_003f_ffff;
   // timing
   localparam int OAC_CLK_NS       = 50;
   localparam int OAC_SWRST_NS     = 200;
   localparam int OAC_SWRST_CYCLES = (OAC_SWRST_NS + OAC_CLK_NS - 1) / OAC_CLK_NS;
   // serial slave address, value arbitrary
   localparam logic [6:0]  OAC_DEV_ADDR   = 7'h2a;
   // effect codes
   localparam logic [3:0] OAC_FX_NORMAL  = 4'h0;
   localparam logic [3:0] OAC_FX_BLINK   = 4'h1;
   localparam logic [3:0] OAC_FX_SHADOW  = 4'h2;
   localparam logic [3:0] OAC_FX_BORDER  = 4'h3;
   localparam logic [3:0] OAC_FX_RAISED  = 4'h8;
   localparam logic [3:0] OAC_FX_DEPRESS = 4'ha;
   localparam logic [3:0] OAC_FX_HRAISED = 4'hc;
   localparam logic [3:0] OAC_FX_HDEPRES = 4'he;

   typedef struct packed {
      logic [2:0] blue;
      logic [2:0] green;
      logic [2:0] red;
   } oac_colour_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [7:0]  data;
   } oac_wr_t;

   typedef struct packed {
      logic blink;
      logic shadow;
      logic border;
      logic box_raised;
      logic box_depressed;
      logic box_heavy;
   } oac_effect_t;

   typedef struct packed {
      logic       valid;
      logic       four_colour;
      logic [3:0] index;
      logic [1:0] pixel;
   } oac_ovl_req_t;
endpackage

// ==== src/oac_serial_slave.sv ====
`timescale 1ns/10ps
module oac_serial_slave
   import oac_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output wire logic        sda_out,
   output wire logic        sda_oe,
   input  wire logic        addr_autoinc_disable,
   input  wire logic [7:0]  rd_data,
   output wire logic [15:0] cur_addr,
   output oac_wr_t          wr
);
   typedef enum {OAC_ST_IDLE, OAC_ST_RX, OAC_ST_RX_ACK, OAC_ST_TX, OAC_ST_TX_ACK} oac_sstate_t;

   logic        scl_meta_reg, scl_sync_reg, scl_prev_reg;
   logic        sda_meta_reg, sda_sync_reg, sda_prev_reg;
   oac_sstate_t state_reg;
   logic [7:0]  shift_reg;
   logic [3:0]  bit_cnt_reg;
   logic [1:0]  byte_idx_reg;
   logic        is_read_reg;
   logic        master_ack_reg;
   logic        oe_reg;
   logic [15:0] addr_reg;
   oac_wr_t     wr_reg;
   logic        scl_rise, scl_fall, start_seen, stop_seen;

   // pins pass two flops before any decode
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_meta_reg <= scl_in;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_in;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
      end
   end

   assign scl_rise   = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall   = ~scl_sync_reg & scl_prev_reg;
   assign start_seen = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
   assign stop_seen  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

   // protocol engine; only the hard reset touches it, so transfers survive soft reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg      <= OAC_ST_IDLE;
         shift_reg      <= 8'h00;
         bit_cnt_reg    <= 4'h0;
         byte_idx_reg   <= 2'h0;
         is_read_reg    <= 1'b0;
         master_ack_reg <= 1'b0;
         oe_reg         <= 1'b0;
         addr_reg       <= 16'h0000;
         wr_reg         <= '0;
      end else begin
         wr_reg.valid <= 1'b0;
         if (start_seen) begin
            state_reg    <= OAC_ST_RX;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'h0;
            oe_reg       <= 1'b0;
         end else if (stop_seen) begin
            state_reg <= OAC_ST_IDLE;
            oe_reg    <= 1'b0;
         end else begin
            unique case (state_reg)
               OAC_ST_IDLE: begin
               end
               OAC_ST_RX: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_sync_reg};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     state_reg <= OAC_ST_RX_ACK;
                     oe_reg    <= 1'b1;
                     unique case (byte_idx_reg)
                        2'h0: begin
                           if (shift_reg[7:1] == OAC_DEV_ADDR) begin
                              is_read_reg  <= shift_reg[0];
                              byte_idx_reg <= 2'h1;
                           end else begin
                              state_reg <= OAC_ST_IDLE;
                              oe_reg    <= 1'b0;
                           end
                        end
                        2'h1: begin
                           addr_reg[15:8] <= shift_reg;
                           byte_idx_reg   <= 2'h2;
                        end
                        2'h2: begin
                           addr_reg[7:0] <= shift_reg;
                           byte_idx_reg  <= 2'h3;
                        end
                        2'h3: begin
                           wr_reg.valid <= 1'b1;
                           wr_reg.addr  <= addr_reg;
                           wr_reg.data  <= shift_reg;
                           if (!addr_autoinc_disable)
                              addr_reg <= addr_reg + 16'h0001;
                        end
                     endcase
                  end
               end
               OAC_ST_RX_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (is_read_reg && byte_idx_reg == 2'h1) begin
                        state_reg <= OAC_ST_TX;
                        shift_reg <= rd_data;
                        oe_reg    <= ~rd_data[7];
                     end else begin
                        state_reg <= OAC_ST_RX;
                        oe_reg    <= 1'b0;
                     end
                  end
               end
               OAC_ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == 4'h7) begin
                        state_reg <= OAC_ST_TX_ACK;
                        oe_reg    <= 1'b0;
                     end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                        oe_reg      <= ~shift_reg[6];
                     end
                  end
               end
               OAC_ST_TX_ACK: begin
                  if (scl_rise) begin
                     master_ack_reg <= ~sda_sync_reg;
                     if (!addr_autoinc_disable)
                        addr_reg <= addr_reg + 16'h0001;
                  end else if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (master_ack_reg) begin
                        state_reg <= OAC_ST_TX;
                        shift_reg <= rd_data;
                        oe_reg    <= ~rd_data[7];
                     end else begin
                        state_reg <= OAC_ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // open drain: only ever pulls low
   assign sda_out  = 1'b0;
   assign sda_oe   = oe_reg;
   assign cur_addr = addr_reg;
   assign wr       = wr_reg;
endmodule

// ==== src/oac_regs.sv ====
`timescale 1ns/10ps
module oac_regs
   import oac_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output wire logic        sda_out,
   output wire logic        sda_oe,
   input  oac_ovl_req_t     ovl_req,
   input  wire logic        blink_phase,
   input  oac_colour_t      video_in,
   input  wire logic        vblank_in,
   input  wire logic        clamp_in,
   output oac_colour_t      ovl_colour,
   output oac_effect_t      ovl_effect,
   output wire logic        ovl_valid,
   output oac_colour_t      video_out,
   output wire logic        clamp_active,
   output wire logic        overlay_only_override,
   output wire logic        vertical_blank_enable,
   output wire logic [1:0]  scan_range,
   output wire logic        soft_reset_busy
);
   logic [7:0]  scan_reg;
   logic        addr_autoinc_disable_reg;
   logic [2:0]  swrst_cnt_reg;
   logic [7:0]  att2_mem [OAC_ATT2_BYTES];
   logic [7:0]  att4_mem [OAC_ATT4_BYTES];
   logic [15:0] cur_addr;
   logic [7:0]  rd_data;
   oac_wr_t     wr;
   logic        swrst_busy;
   logic        clamp_meta_reg, clamp_sync_reg, clamp_active_reg;
   oac_colour_t ovl_colour_reg, video_out_reg;
   oac_effect_t ovl_effect_reg;
   logic        ovl_valid_reg;
   logic [15:0] att2_off, att4_off;
   logic        hit_att2, hit_att4;

   oac_serial_slave u_slave (
      .clk_sys              (clk_sys),
      .rstn                 (rstn),
      .scl_in               (scl_in),
      .sda_in               (sda_in),
      .sda_out              (sda_out),
      .sda_oe               (sda_oe),
      .addr_autoinc_disable (addr_autoinc_disable_reg),
      .rd_data              (rd_data),
      .cur_addr             (cur_addr),
      .wr                   (wr)
   );

   assign swrst_busy = (swrst_cnt_reg != 3'h0);
   assign att2_off   = wr.addr - OAC_ATT2_BASE;
   assign att4_off   = wr.addr - OAC_ATT4_BASE;
   assign hit_att2   = (wr.addr >= OAC_ATT2_BASE) && (att2_off < 16'(OAC_ATT2_BYTES));
   assign hit_att4   = (wr.addr >= OAC_ATT4_BASE) && (att4_off < 16'(OAC_ATT4_BYTES));

   // soft reset sequencer; a new trigger write restarts the count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         swrst_cnt_reg <= 3'h0;
      end else if (wr.valid && wr.addr == OAC_SRT_ADDR && wr.data[OAC_SWRST_BIT]) begin
         swrst_cnt_reg <= 3'(OAC_SWRST_CYCLES);
      end else if (swrst_busy) begin
         swrst_cnt_reg <= swrst_cnt_reg - 3'h1;
      end
   end

   // auto-increment disable lives in the one register soft reset spares
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addr_autoinc_disable_reg <= OAC_SRT_RESET[OAC_AID_BIT];
      end else if (wr.valid && wr.addr == OAC_SRT_ADDR) begin
         addr_autoinc_disable_reg <= wr.data[OAC_AID_BIT];
      end
   end

   // scan range and override control; held at default while soft reset runs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         scan_reg <= OAC_SCAN_RESET;
      end else if (swrst_busy) begin
         scan_reg <= OAC_SCAN_RESET;
      end else if (wr.valid && wr.addr == OAC_SCAN_ADDR) begin
         scan_reg <= wr.data & OAC_SCAN_MASK;
      end
   end

   // attribute tables; reserved bits are not stored so they read as zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < OAC_ATT2_BYTES; i++)
            att2_mem[i] <= OAC_ATT_RESET;
         for (int i = 0; i < OAC_ATT4_BYTES; i++)
            att4_mem[i] <= OAC_ATT_RESET;
      end else if (swrst_busy) begin
         for (int i = 0; i < OAC_ATT2_BYTES; i++)
            att2_mem[i] <= OAC_ATT_RESET;
         for (int i = 0; i < OAC_ATT4_BYTES; i++)
            att4_mem[i] <= OAC_ATT_RESET;
      end else if (wr.valid && hit_att2) begin
         att2_mem[att2_off[5:0]] <= wr.data & OAC_ATT2_MASK[8*att2_off[1:0] +: 8];
      end else if (wr.valid && hit_att4) begin
         att4_mem[att4_off[6:0]] <= wr.data & OAC_ATT4_MASK[8*att4_off[2:0] +: 8];
      end
   end

   // read mux on the slave's current address; unmapped reads as zero
   always_comb begin
      logic [15:0] o2, o4;
      o2      = cur_addr - OAC_ATT2_BASE;
      o4      = cur_addr - OAC_ATT4_BASE;
      rd_data = 8'h00;
      if (cur_addr == OAC_SCAN_ADDR)
         rd_data = scan_reg;
      else if (cur_addr == OAC_SRT_ADDR)
         rd_data = {1'b0, addr_autoinc_disable_reg, 5'h00, swrst_busy};
      else if (cur_addr >= OAC_ATT2_BASE && o2 < 16'(OAC_ATT2_BYTES))
         rd_data = att2_mem[o2[5:0]];
      else if (cur_addr >= OAC_ATT4_BASE && o4 < 16'(OAC_ATT4_BYTES))
         rd_data = att4_mem[o4[6:0]];
   end

   // overlay lookup: index picks an entry, character type picks the table
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ovl_colour_reg <= '0;
         ovl_effect_reg <= '0;
         ovl_valid_reg  <= 1'b0;
      end else begin
         logic [63:0] ent;
         logic [3:0]  fx;
         logic [1:0]  pix;
         logic        hide;
         for (int b = 0; b < 8; b++) begin
            if (ovl_req.four_colour)
               ent[8*b +: 8] = att4_mem[{ovl_req.index, 3'(b)}];
            else
               ent[8*b +: 8] = (b < 4) ? att2_mem[{ovl_req.index, 2'(b)}] : 8'h00;
         end
         fx   = ent[OAC_FX_LSB +: 4];
         pix  = ovl_req.four_colour ? ovl_req.pixel : {1'b0, ovl_req.pixel[0]};
         // blink hides the foreground in the off phase; odd box codes 9, b, d and f blink too
         hide = (fx == OAC_FX_BLINK || (fx[3] && fx[0])) && !blink_phase;
         if (hide)
            pix = 2'b00;
         unique case (pix)
            2'b00: ovl_colour_reg <= ent[OAC_C1_LSB +: 9];
            2'b01: ovl_colour_reg <= ent[OAC_C2_LSB +: 9];
            2'b10: ovl_colour_reg <= ent[OAC_C3_LSB +: 9];
            2'b11: ovl_colour_reg <= ent[OAC_C4_LSB +: 9];
         endcase
         ovl_effect_reg.blink         <= (fx == OAC_FX_BLINK) ||
                                         (fx[3] && fx[0]);
         ovl_effect_reg.shadow        <= (fx == OAC_FX_SHADOW);
         ovl_effect_reg.border        <= (fx == OAC_FX_BORDER);
         ovl_effect_reg.box_raised    <= fx[3] && ({fx[3:1], 1'b0} == OAC_FX_RAISED ||
                                                   {fx[3:1], 1'b0} == OAC_FX_HRAISED);
         ovl_effect_reg.box_depressed <= fx[3] && ({fx[3:1], 1'b0} == OAC_FX_DEPRESS ||
                                                   {fx[3:1], 1'b0} == OAC_FX_HDEPRES);
         ovl_effect_reg.box_heavy     <= fx[3] && fx[2];
         // overlay lookups abort while soft reset runs
         ovl_valid_reg                <= ovl_req.valid && !swrst_busy;
      end
   end

   // clamp pin is asynchronous, so it is synchronised before the polarity xor
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         clamp_meta_reg   <= 1'b0;
         clamp_sync_reg   <= 1'b0;
         clamp_active_reg <= 1'b0;
      end else begin
         clamp_meta_reg   <= clamp_in;
         clamp_sync_reg   <= clamp_meta_reg;
         clamp_active_reg <= clamp_sync_reg ^ scan_reg[OAC_CLAMP_BIT];
      end
   end

   // video output mux: blanking first, then overlay, then override black, then video
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         video_out_reg <= '0;
      end else if (scan_reg[OAC_VBLANK_BIT] && vblank_in) begin
         video_out_reg <= '0;
      end else if (ovl_valid_reg) begin
         video_out_reg <= ovl_colour_reg;
      end else if (scan_reg[OAC_OVR_BIT]) begin
         video_out_reg <= '0;
      end else begin
         video_out_reg <= video_in;
      end
   end

   assign ovl_colour            = ovl_colour_reg;
   assign ovl_effect            = ovl_effect_reg;
   assign ovl_valid             = ovl_valid_reg;
   assign video_out             = video_out_reg;
   assign clamp_active          = clamp_active_reg;
   assign overlay_only_override = scan_reg[OAC_OVR_BIT];
   assign vertical_blank_enable = scan_reg[OAC_VBLANK_BIT];
   assign scan_range            = scan_reg[OAC_SCAN_RNG_LSB +: 2];
   assign soft_reset_busy       = swrst_busy;
endmodule

// ==== test/oac_regs_asserts.sv ====
`timescale 1ns/10ps
module oac_regs_asserts
   import oac_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rstn,
   input oac_ovl_req_t    ovl_req,
   input oac_colour_t     video_in,
   input wire logic       vblank_in,
   input oac_colour_t     ovl_colour,
   input wire logic       ovl_valid,
   input oac_colour_t     video_out,
   input wire logic       overlay_only_override,
   input wire logic       vertical_blank_enable,
   input wire logic [1:0] scan_range,
   input wire logic       soft_reset_busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // blanking wins over every other source of the output mux
   wire logic blank = vertical_blank_enable & vblank_in;
   vblank_gate_a: assert property (blank |=> video_out == '0)
      else $error("video not blanked");
   override_black_a: assert property (!blank && !ovl_valid && overlay_only_override |=> video_out == '0)
      else $error("video leaked under override");
   video_pass_a: assert property (!blank && !ovl_valid && !overlay_only_override |=> video_out == $past(video_in))
      else $error("video not passed through");
   overlay_show_a: assert property (!blank && ovl_valid |=> video_out == $past(ovl_colour))
      else $error("overlay colour not shown");
   req_valid_a: assert property (ovl_req.valid && !soft_reset_busy ##1 !soft_reset_busy |-> ovl_valid)
      else $error("overlay request dropped");
   req_idle_a: assert property (!ovl_req.valid |=> !ovl_valid)
      else $error("overlay valid without request");
   swrst_end_a: assert property ($rose(soft_reset_busy) |-> ##[1:8] !soft_reset_busy)
      else $error("soft reset never finished");
   swrst_clear_a: assert property (soft_reset_busy |=> !overlay_only_override && !vertical_blank_enable && scan_range == 2'h0)
      else $error("scan register kept through soft reset");
   cover property ($rose(soft_reset_busy));
   cover property (blank);
   cover property (ovl_valid && overlay_only_override);
endmodule
bind oac_regs oac_regs_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn), .ovl_req(ovl_req), .video_in(video_in),
   .vblank_in(vblank_in), .ovl_colour(ovl_colour), .ovl_valid(ovl_valid), .video_out(video_out),
   .overlay_only_override(overlay_only_override), .vertical_blank_enable(vertical_blank_enable),
   .scan_range(scan_range), .soft_reset_busy(soft_reset_busy));

// ==== test/oac_i2c_host.sv ====
`timescale 1ns/10ps
module oac_i2c_host
   import oac_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // a third of an scl bit period (high for one, low for two); well above the 3-cycle pin sync of the slave
   localparam int HALF = 8;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hw();
      repeat (HALF) @(negedge clk_sys);
   endtask
   // also a repeated start: scl is low and sda released on entry
   task automatic start();
      sda_low = 1'b0;
      hw();
      scl = 1'b1;
      hw();
      sda_low = 1'b1;
      hw();
      scl = 1'b0;
      hw();
   endtask
   task automatic stop();
      sda_low = 1'b1;
      hw();
      scl = 1'b1;
      hw();
      sda_low = 1'b0;
      hw();
   endtask
   // data changes only one HALF interval after scl falls, mid-way through the scl low phase
   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      hw();
      scl = 1'b1;
      hw();
      r = sda;
      scl = 1'b0;
      hw();
   endtask
   task automatic tx(input logic [7:0] b, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ok = ok & ~r;
   endtask
   // bytes follow back to back, low byte first, from one address
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input int n, output logic ok);
      ok = 1'b1;
      start();
      tx({OAC_DEV_ADDR, 1'b0}, ok);
      tx(a[15:8], ok);
      tx(a[7:0], ok);
      for (int i = 0; i < n; i++) tx(d[8*i +: 8], ok);
      stop();
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
      logic r;
      ok = 1'b1;
      start();
      tx({OAC_DEV_ADDR, 1'b0}, ok);
      tx(a[15:8], ok);
      tx(a[7:0], ok);
      start();
      tx({OAC_DEV_ADDR, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
      stop();
   endtask
endmodule

// ==== test/oac_regs_tb.sv ====
`timescale 1ns/10ps
module oac_regs_tb;
   import oac_pkg::*;
   logic         clk_sys, rstn, scl, sda_low, blink_phase, vblank_in, clamp_in;
   wire logic    sda, sda_out, sda_oe, ovl_valid, clamp_active, ovr, vben, busy;
   wire logic [1:0] scan_range;
   oac_ovl_req_t ovl_req;
   oac_colour_t  video_in, ovl_colour, video_out;
   oac_effect_t  ovl_effect;
   int           err_count, tests_run, busy_cycles;
   // open drain with pull-up
   assign sda = ~(sda_oe | sda_low);
   oac_regs dut (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .ovl_req(ovl_req), .blink_phase(blink_phase), .video_in(video_in), .vblank_in(vblank_in),
      .clamp_in(clamp_in), .ovl_colour(ovl_colour), .ovl_effect(ovl_effect), .ovl_valid(ovl_valid),
      .video_out(video_out), .clamp_active(clamp_active), .overlay_only_override(ovr),
      .vertical_blank_enable(vben), .scan_range(scan_range), .soft_reset_busy(busy));
   oac_i2c_host host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (busy === 1'b1) busy_cycles++;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic w(input logic [15:0] a, input logic [31:0] d, input int n);
      logic ok;
      host.wr(a, d, n, ok);
      chk("ack", 1, ok);
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host.rd(a, d, ok);
      chk("ack", 1, ok);
      chk($sformatf("reg %h", a), exp, d);
   endtask
   task automatic t_defaults();
      logic [15:0] addrs[4] = '{OAC_SCAN_ADDR, OAC_SRT_ADDR, 16'h8454, 16'h8000};
      foreach (addrs[i]) rchk(addrs[i], 8'h00);
      $display("test defaults done");
   endtask
   task automatic t_scan();
      w(OAC_SCAN_ADDR, 8'h2f, 1);
      tick(4);
      chk("scan outputs", 4'hf, {ovr, vben, scan_range});
      rchk(OAC_SCAN_ADDR, 8'h2f);
      w(OAC_SCAN_ADDR, 8'h08, 1);
      tick(3);
      chk("override black", 0, video_out);
      w(OAC_SCAN_ADDR, 8'h24, 1);
      vblank_in = 1'b1;
      tick(3);
      chk("vblank black", 0, video_out);
      vblank_in = 1'b0;
      tick(3);
      chk("video through", 9'h1a5, video_out);
      clamp_in = 1'b1;
      tick(6);
      chk("clamp negative", 0, clamp_active);
      clamp_in = 1'b0;
      tick(6);
      chk("clamp negative", 1, clamp_active);
      w(OAC_SCAN_ADDR, 8'h00, 1);
      tick(6);
      chk("clamp positive", 0, clamp_active);
      clamp_in = 1'b1;
      tick(6);
      chk("clamp positive", 1, clamp_active);
      clamp_in = 1'b0;
      $display("test scan done");
   endtask
   task automatic t_attr();
      // entry 5: effect blink, fg {4,7,2}, bg {3,0,5}
      w(16'h8454, {10'h0, 4'h1, 9'h13a, 9'h0c5}, 4);
      rchk(16'h8456, 8'h06);
      ovl_req = {1'b1, 1'b0, 4'd5, 2'd0};
      blink_phase = 1'b1;
      tick(2);
      chk("bg", 9'h0c5, ovl_colour);
      chk("effect", 6'h20, ovl_effect);
      ovl_req.pixel = 2'd1;
      tick(2);
      chk("fg", 9'h13a, ovl_colour);
      blink_phase = 1'b0;
      tick(2);
      chk("blink off", 9'h0c5, ovl_colour);
      ovl_req.index = 4'd4;
      tick(2);
      chk("other entry", 0, ovl_colour);
      w(16'h852c, 16'h0155, 2);
      ovl_req = {1'b1, 1'b1, 4'd5, 2'd2};
      tick(2);
      chk("four colour", 9'h155, ovl_colour);
      $display("test attr done");
   endtask
   task automatic t_effects();
      logic [3:0] c;
      logic [5:0] e;
      ovl_req = {1'b1, 1'b0, 4'd5, 2'd1};
      blink_phase = 1'b0;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         e = {c[0] && c != 4'h3 && c[3:2] != 2'b01, c == 4'h2, c == 4'h3, c[3] & ~c[1], c[3] & c[1], c[3] & c[2]};
         w(16'h8456, {2'b00, c, 2'b10}, 1);
         tick(2);
         chk($sformatf("effect %h", c), e, ovl_effect);
         chk($sformatf("colour %h", c), e[5] ? 9'h0c5 : 9'h13a, ovl_colour);
      end
      $display("test effects done");
   endtask
   task automatic t_aid();
      w(OAC_SRT_ADDR, 8'h40, 1);
      w(16'h8440, 16'hbbaa, 2);
      rchk(16'h8440, 8'hbb);
      rchk(16'h8441, 8'h00);
      rchk(OAC_SRT_ADDR, 8'h40);
      w(OAC_SRT_ADDR, 8'h00, 1);
      $display("test aid done");
   endtask
   task automatic t_swrst();
      w(OAC_SCAN_ADDR, 8'h2f, 1);
      busy_cycles = 0;
      // the byte after the trigger must still land
      w(OAC_SRT_ADDR, 16'h5a01, 2);
      chk("busy length", OAC_SWRST_CYCLES, busy_cycles);
      chk("scan after reset", 0, {ovr, vben, scan_range});
      rchk(OAC_SRT_ADDR, 8'h00);
      rchk(16'h8454, 8'h00);
      rchk(16'h8440, 8'h5a);
      $display("test soft reset done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      ovl_req = '0;
      blink_phase = 1'b0;
      vblank_in = 1'b0;
      clamp_in = 1'b0;
      video_in = 9'h1a5;
      repeat (20) @(negedge clk_sys);
      rstn = 1'b1;
      tick(3);
      t_defaults();
      t_scan();
      t_attr();
      t_effects();
      t_aid();
      t_swrst();
      report_and_stop();
   end
   // about 40k cycles of traffic expected
   initial begin
      repeat (90000) @(posedge clk_sys);
      err_count++;
      report_and_stop();
   end
endmodule
